//--- pmw_board.sv
`timescale 1ns/1ps
// board side of the shared pins: external drivers plus pull-ups on every line
module pmw_board #(
  parameter int W = 7
) (
  // device side of each pin
  input wire logic [W-1:0] dev_out_i,
  input wire logic [W-1:0] dev_oe_i,
  // external drivers, one enable per line
  input wire logic [W-1:0] ext_val_i,
  input wire logic [W-1:0] ext_en_i,
  // resolved pin level
  output logic [W-1:0] pin_o
);
  // device wins where it drives; contention itself is not modelled
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (dev_oe_i[i]) begin
        pin_o[i] = dev_out_i[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else begin
        pin_o[i] = 1'b1; // released line floats to the pull-up
      end
    end
  end
endmodule

//--- pmw_pin_mux.sv
`timescale 1ns/1ps
// Functional notes
// - while suspended, asserted wake pin restarts oscillator and raises interrupt
// - wake pin held asserted refuses entry to suspend
// - wake pin active level follows wake control bit 4
// - alt config bit 0 makes port A bit 0 the first interrupt input
// - first interrupt active low, edge when its type bit is 1, else level
// - alt config bit 1 makes bit 1 second interrupt, same edge/level choice
// - slave FIFO mode makes bit 2 input output-enable, polarity FIFO bit 4
// - bit 3 function chosen by wake control bit 7 and output enable bit 3
// - enabled second wake source asserted blocks suspend entry
// - second wake source polarity is wake control bit 4
// - slave FIFO mode makes bits 4 and 5 input FIFO selects
// - NAND mode: bits 0,1 latch enables, 4 protect out, 5 protect switch in
// - NAND mode: bits 2 and 3 sink current for the activity LEDs
// - port E bit 0 is general I/O line 8, input after reset
module pmw_pin_mux
  import pmw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [pmw_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pmw_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pmw_pkg::DATA_W-1:0] rdata_o,
  // port A pins (input, output, output enable)
  input wire logic [pmw_pkg::PA_W-1:0] port_a_in_i,
  output logic [pmw_pkg::PA_W-1:0] port_a_out_o,
  output logic [pmw_pkg::PA_W-1:0] port_a_oe_o,
  // port E bit 0 and dedicated wake pin
  input wire logic general_io_line_8_in_i,
  output logic general_io_line_8_out_o,
  output logic general_io_line_8_oe_o,
  input wire logic wake_pin_i,
  // NAND firmware signals to and from the core
  input wire logic nand_cle_i,
  input wire logic nand_ale_i,
  input wire logic flash_write_protect_n_i,
  input wire logic data_activity_led_n_i,
  input wire logic chip_activity_led_n_i,
  output logic write_protect_switch_n_o,
  // FIFO side
  output logic fifo_output_enable_o,
  output logic [1:0] fifo_select_o,
  // processor side
  output logic ext_irq_first_o,
  output logic ext_irq_second_o,
  output logic osc_enable_o,
  output logic suspended_o,
  output logic irq_o
);
  logic [7:0] pa_out_reg, port_a_output_enable, port_a_alt_config, interface_config;
  logic [7:0] fifo_pin_polarity, wake_ctl, pe_reg, ctrl, mask;
  logic [STATUS_W-1:0] status, next_status;
  logic [7:0] pins_s;
  logic [5:0] pa_s;
  logic pe_s, wake_s, bit0_prev, bit1_prev, bit3_prev;
  logic slave_fifo, nand_mode, bit3_is_wake, wake_act, wake2_act, wake2_edge, inhibit;
  logic susp_req, wake_now, status_rd;
  logic [5:0] next_pa_out, next_pa_oe;
  pmw_state_t state;

  pmw_sync #(.WIDTH(8)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i({wake_pin_i, general_io_line_8_in_i, port_a_in_i}),
    .sync_o(pins_s)
  );
  assign pa_s = pins_s[5:0];
  assign pe_s = pins_s[6];
  assign wake_s = pins_s[7];

  // pin function decode
  assign slave_fifo = interface_config[1:0] == IFC_SLAVE_FIFO;
  assign nand_mode = ctrl[CTRL_NAND];
  assign bit3_is_wake = wake_ctl[WCTL_BIT3_SEL] & ~port_a_output_enable[OE_BIT3];
  // polarity bit set means active high
  assign wake_act = wake_s ^ ~wake_ctl[WCTL_POL];
  assign wake2_act = pa_s[3] ^ ~wake_ctl[WCTL_POL];
  assign wake2_edge = bit3_is_wake & wake_ctl[WCTL_WAKE2_EN] & (pa_s[3] != bit3_prev);
  assign inhibit = wake_act | (bit3_is_wake & wake_ctl[WCTL_WAKE2_EN] & wake2_act);
  assign susp_req = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_SUSPEND];
  assign wake_now = state == PMW_SUSP && (wake_act || wake2_edge);
  assign status_rd = rd_i && addr_i == REG_STATUS;

  // register writes; the suspend bit is a command and is not stored
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pa_out_reg <= RST_BYTE;
      port_a_output_enable <= RST_BYTE;
      port_a_alt_config <= RST_BYTE;
      interface_config <= RST_BYTE;
      fifo_pin_polarity <= RST_BYTE;
      wake_ctl <= RST_BYTE;
      pe_reg <= RST_BYTE;
      ctrl <= RST_BYTE;
      mask <= RST_BYTE;
    end else if (wr_i) begin
      case (addr_i)
        REG_PA_OUT: pa_out_reg <= wdata_i;
        REG_PA_OE: port_a_output_enable <= wdata_i;
        REG_ALT_CFG: port_a_alt_config <= wdata_i;
        REG_IF_CFG: interface_config <= wdata_i;
        REG_FIFO_POL: fifo_pin_polarity <= wdata_i;
        REG_WAKE_CTL: wake_ctl <= wdata_i;
        REG_PE: pe_reg <= wdata_i;
        REG_CTRL: ctrl <= wdata_i & ~(8'h01 << CTRL_SUSPEND);
        REG_MASK: mask <= wdata_i;
        default: ;
      endcase
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        REG_PA_OUT: rdata_o <= pa_out_reg;
        REG_PA_OE: rdata_o <= port_a_output_enable;
        REG_ALT_CFG: rdata_o <= port_a_alt_config;
        REG_IF_CFG: rdata_o <= interface_config;
        REG_FIFO_POL: rdata_o <= fifo_pin_polarity;
        REG_WAKE_CTL: rdata_o <= wake_ctl;
        REG_PE: rdata_o <= pe_reg;
        REG_CTRL: rdata_o <= ctrl;
        REG_STATUS: rdata_o <= {3'h0, status};
        REG_MASK: rdata_o <= mask;
        REG_PINS: rdata_o <= pins_s;
        REG_STATE: rdata_o <= {4'h0, fifo_output_enable_o, fifo_select_o, suspended_o};
        default: rdata_o <= RST_BYTE;
      endcase
    end else begin
      rdata_o <= RST_BYTE;
    end
  end

  // power state; a refused request leaves a sticky flag instead
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= PMW_RUN;
    end else begin
      case (state)
        PMW_RUN: if (susp_req && !inhibit) begin
          state <= PMW_SUSP;
        end
        PMW_SUSP: if (wake_now) begin
          state <= PMW_RUN;
        end
        default: state <= PMW_RUN;
      endcase
    end
  end

  // previous samples for edge detection
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bit0_prev <= 1'b1;
      bit1_prev <= 1'b1;
      bit3_prev <= 1'b1; // matches the synchroniser's reset level
    end else begin
      bit0_prev <= pa_s[0];
      bit1_prev <= pa_s[1];
      bit3_prev <= pa_s[3];
    end
  end

  // sticky events; a set in the same cycle as a read-clear wins
  always_comb begin
    next_status = status_rd ? RST_STATUS : status;
    if (port_a_alt_config[ALT_FIRST_IRQ] && ctrl[CTRL_IT_FIRST] && bit0_prev && !pa_s[0]) begin
      next_status[ST_IRQ_FIRST] = 1'b1;
    end
    if (port_a_alt_config[ALT_SECOND_IRQ] && ctrl[CTRL_IT_SECOND] && bit1_prev && !pa_s[1]) begin
      next_status[ST_IRQ_SECOND] = 1'b1;
    end
    if (state == PMW_SUSP && wake_act) begin
      next_status[ST_WAKE_PIN] = 1'b1;
    end
    if (state == PMW_SUSP && wake2_edge) begin
      next_status[ST_WAKE_SECOND] = 1'b1;
    end
    if (state == PMW_RUN && susp_req && inhibit) begin
      next_status[ST_REFUSED] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      status <= RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // pin drive priority: NAND firmware, then FIFO and alternate inputs, then port bits
  always_comb begin
    next_pa_out = pa_out_reg[5:0];
    next_pa_oe = port_a_output_enable[5:0];
    if (nand_mode) begin
      next_pa_out = {1'b0, flash_write_protect_n_i, 2'b00, nand_ale_i, nand_cle_i};
      next_pa_oe = {1'b0, 1'b1, ~chip_activity_led_n_i, ~data_activity_led_n_i, 2'b11};
    end else begin
      if (port_a_alt_config[ALT_FIRST_IRQ]) next_pa_oe[0] = 1'b0;
      if (port_a_alt_config[ALT_SECOND_IRQ]) next_pa_oe[1] = 1'b0;
      if (bit3_is_wake) next_pa_oe[3] = 1'b0;
      if (slave_fifo) begin
        next_pa_oe[2] = 1'b0;
        next_pa_oe[5:4] = 2'b00;
      end
    end
  end

  // pins and processor-facing outputs, all registered
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      port_a_out_o <= RST_PA;
      port_a_oe_o <= RST_PA;
      general_io_line_8_out_o <= 1'b0;
      general_io_line_8_oe_o <= 1'b0;
      write_protect_switch_n_o <= 1'b1;
      fifo_output_enable_o <= 1'b0;
      fifo_select_o <= 2'h0;
      ext_irq_first_o <= 1'b0;
      ext_irq_second_o <= 1'b0;
      osc_enable_o <= 1'b1;
      suspended_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      port_a_out_o <= next_pa_out;
      port_a_oe_o <= next_pa_oe;
      general_io_line_8_out_o <= pe_reg[PE_OUT];
      general_io_line_8_oe_o <= pe_reg[PE_OE];
      write_protect_switch_n_o <= nand_mode ? pa_s[5] : 1'b1;
      fifo_output_enable_o <= slave_fifo & ~nand_mode
        & (pa_s[2] ^ ~fifo_pin_polarity[FPOL_OE]);
      fifo_select_o <= (slave_fifo & ~nand_mode) ? pa_s[5:4] : 2'h0;
      ext_irq_first_o <= port_a_alt_config[ALT_FIRST_IRQ] & ~nand_mode
        & (ctrl[CTRL_IT_FIRST] ? next_status[ST_IRQ_FIRST] : ~pa_s[0]);
      ext_irq_second_o <= port_a_alt_config[ALT_SECOND_IRQ] & ~nand_mode
        & (ctrl[CTRL_IT_SECOND] ? next_status[ST_IRQ_SECOND] : ~pa_s[1]);
      osc_enable_o <= !(state == PMW_RUN ? (susp_req && !inhibit) : !wake_now);
      suspended_o <= state == PMW_RUN ? (susp_req && !inhibit) : !wake_now;
      irq_o <= |(next_status & mask[STATUS_W-1:0]);
    end
  end

  // checks
  property p_wake_resumes;
    @(posedge clk_i) disable iff (!rstn_i)
      (state == PMW_SUSP && wake_act) |=> (state == PMW_RUN && osc_enable_o);
  endproperty
  a_wake_resumes: assert property (p_wake_resumes) else $error("wake did not resume");

  property p_no_suspend_inhibited;
    @(posedge clk_i) disable iff (!rstn_i)
      (state == PMW_RUN && susp_req && inhibit) |=> (state == PMW_RUN && status[ST_REFUSED]);
  endproperty
  a_no_suspend_inhibited: assert property (p_no_suspend_inhibited) else $error("suspend not refused");

  property p_suspend_taken;
    @(posedge clk_i) disable iff (!rstn_i)
      (state == PMW_RUN && susp_req && !inhibit) |=> (suspended_o && !osc_enable_o);
  endproperty
  a_suspend_taken: assert property (p_suspend_taken) else $error("suspend not entered");

  property p_first_edge;
    @(posedge clk_i) disable iff (!rstn_i)
      (port_a_alt_config[ALT_FIRST_IRQ] && ctrl[CTRL_IT_FIRST] && bit0_prev && !pa_s[0])
        |=> status[ST_IRQ_FIRST];
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first irq edge lost");

  property p_second_level;
    @(posedge clk_i) disable iff (!rstn_i)
      (port_a_alt_config[ALT_SECOND_IRQ] && !ctrl[CTRL_IT_SECOND] && !nand_mode && !pa_s[1])
        |=> ext_irq_second_o;
  endproperty
  a_second_level: assert property (p_second_level) else $error("second irq level missed");

  property p_fifo_inputs;
    @(posedge clk_i) disable iff (!rstn_i)
      (slave_fifo && !nand_mode) |=> (port_a_oe_o[2] == 1'b0 && port_a_oe_o[5:4] == 2'b00);
  endproperty
  a_fifo_inputs: assert property (p_fifo_inputs) else $error("fifo pins driven");

  property p_wake2_input;
    @(posedge clk_i) disable iff (!rstn_i)
      (bit3_is_wake && !nand_mode) |=> !port_a_oe_o[3];
  endproperty
  a_wake2_input: assert property (p_wake2_input) else $error("second wake pin driven");

  property p_nand_latch;
    @(posedge clk_i) disable iff (!rstn_i)
      nand_mode |=> (port_a_oe_o[1:0] == 2'b11 && port_a_out_o[0] == $past(nand_cle_i));
  endproperty
  a_nand_latch: assert property (p_nand_latch) else $error("latch enable not driven");

  property p_led_sink;
    @(posedge clk_i) disable iff (!rstn_i)
      (nand_mode && !data_activity_led_n_i) |=> (port_a_oe_o[2] && !port_a_out_o[2]);
  endproperty
  a_led_sink: assert property (p_led_sink) else $error("led not sunk");
endmodule

//--- pmw_pkg.sv
package pmw_pkg;
  // register offsets on the plain register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_PA_OUT = 4'h0;
  localparam logic [3:0] REG_PA_OE = 4'h1;
  localparam logic [3:0] REG_ALT_CFG = 4'h2;
  localparam logic [3:0] REG_IF_CFG = 4'h3;
  localparam logic [3:0] REG_FIFO_POL = 4'h4;
  localparam logic [3:0] REG_WAKE_CTL = 4'h5;
  localparam logic [3:0] REG_PE = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MASK = 4'h9;
  localparam logic [3:0] REG_PINS = 4'ha;
  localparam logic [3:0] REG_STATE = 4'hb;
  // field positions
  localparam int ALT_FIRST_IRQ = 0;
  localparam int ALT_SECOND_IRQ = 1;
  localparam int FPOL_OE = 4;
  localparam int WCTL_WAKE2_EN = 1;
  localparam int WCTL_POL = 4;
  localparam int WCTL_BIT3_SEL = 7;
  localparam int OE_BIT3 = 3;
  localparam int PE_OUT = 0;
  localparam int PE_OE = 1;
  localparam int CTRL_IT_FIRST = 0;
  localparam int CTRL_IT_SECOND = 1;
  localparam int CTRL_NAND = 2;
  localparam int CTRL_SUSPEND = 3;
  localparam int ST_IRQ_FIRST = 0;
  localparam int ST_IRQ_SECOND = 1;
  localparam int ST_WAKE_PIN = 2;
  localparam int ST_WAKE_SECOND = 3;
  localparam int ST_REFUSED = 4;
  localparam int STATUS_W = 5;
  localparam int PA_W = 6;
  // interface_config mode field
  localparam logic [1:0] IFC_SLAVE_FIFO = 2'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PA = 6'h00;
  localparam logic [4:0] RST_STATUS = 5'h00;
  // power state
  typedef enum logic [1:0] {
    PMW_RUN = 2'b01,
    PMW_SUSP = 2'b10
  } pmw_state_t;
endpackage

//--- pmw_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts when stages two and three agree
module pmw_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // raw pins and filtered result
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_i) begin
    // start at the pull-up level, so release shows no false edge
    if (!rstn_i) begin
      meta <= '1;
      stage2 <= '1;
      stage3 <= '1;
      sync_o <= '1;
    end else begin
      meta <= pin_i;
      stage2 <= meta;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule

//--- port_a_pin_mux_wakeup_tb.sv
`timescale 1ns/1ps
// compare two values and count the result
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module port_a_pin_mux_wakeup_tb;
  import pmw_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [5:0] port_a_out_o, port_a_oe_o;
  logic general_io_line_8_out_o, general_io_line_8_oe_o;
  logic wake_pin_i = 1'b0;
  logic cle = 1'b0, ale = 1'b0, wp = 1'b1, l1 = 1'b1, l2 = 1'b1;
  logic write_protect_switch_n_o, fifo_output_enable_o;
  logic [1:0] fifo_select_o;
  logic ext_irq_first_o, ext_irq_second_o, osc_enable_o, suspended_o, irq_o;
  logic [6:0] ext_val = 7'h7f;
  logic [6:0] pins;
  int error_cnt = 0;
  int checked = 0;
  logic [3:0] rw_tbl [8] = '{REG_PA_OUT, REG_PA_OE, REG_ALT_CFG, REG_IF_CFG, REG_FIFO_POL,
                             REG_WAKE_CTL, REG_PE, REG_MASK};

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  pmw_pin_mux dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_a_in_i(pins[5:0]),
    .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
    .general_io_line_8_in_i(pins[6]), .general_io_line_8_out_o(general_io_line_8_out_o),
    .general_io_line_8_oe_o(general_io_line_8_oe_o), .wake_pin_i(wake_pin_i),
    .nand_cle_i(cle), .nand_ale_i(ale), .flash_write_protect_n_i(wp),
    .data_activity_led_n_i(l1), .chip_activity_led_n_i(l2),
    .write_protect_switch_n_o(write_protect_switch_n_o),
    .fifo_output_enable_o(fifo_output_enable_o), .fifo_select_o(fifo_select_o),
    .ext_irq_first_o(ext_irq_first_o), .ext_irq_second_o(ext_irq_second_o),
    .osc_enable_o(osc_enable_o), .suspended_o(suspended_o), .irq_o(irq_o));

  pmw_board #(.W(7)) board (.dev_out_i({general_io_line_8_out_o, port_a_out_o}),
    .dev_oe_i({general_io_line_8_oe_o, port_a_oe_o}), .ext_val_i(ext_val),
    .ext_en_i(7'h7f), .pin_o(pins));

  // bits that each register uses; unnamed bits are not compared
  function automatic logic [7:0] msk(input logic [3:0] a);
    case (a)
      REG_PA_OUT, REG_PA_OE: return 8'h3f;
      REG_ALT_CFG, REG_IF_CFG, REG_PE: return 8'h03;
      REG_FIFO_POL: return 8'h10;
      REG_WAKE_CTL: return 8'h92;
      default: return 8'h1f;
    endcase
  endfunction
  // polarity bit set means active high
  function automatic logic fexp(input logic pol, input logic pin);
    return pol ? pin : ~pin;
  endfunction
  // pin level seen by the board: driven bits show the device value
  function automatic logic [6:0] plv(input logic [6:0] o, input logic [6:0] e,
                                     input logic [6:0] x);
    return (e & o) | (~e & x);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // bounded wait for the wake-up to land
  task automatic wait_run();
    cyc(1); // always let an edge pass, so a pin set just before is not overwritten
    for (int i = 0; i < 20 && suspended_o !== 1'b0; i++) cyc(1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end

  initial begin : main
    logic [7:0] d, v, o;
    logic p;
    void'($urandom(70));
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(2);
    `CHK(osc_enable_o, 1'b1)
    `CHK(suspended_o, 1'b0)
    `CHK(general_io_line_8_oe_o, 1'b0)
    // random readback of every writable register except the control register, then back to zero
    foreach (rw_tbl[i]) begin
      v = 8'($urandom);
      wr(rw_tbl[i], v);
      rd(rw_tbl[i], d);
      `CHK(d & msk(rw_tbl[i]), v & msk(rw_tbl[i]))
      wr(rw_tbl[i], 8'h00);
    end
    rd(4'hc, d);
    `CHK(d, 8'h00)
    // plain port pins and general I/O line 8, pin levels read back
    for (int n = 0; n < 4; n++) begin
      v = 8'($urandom);
      o = 8'($urandom);
      ext_val <= 7'($urandom);
      wr(REG_PA_OUT, v);
      wr(REG_PA_OE, o);
      wr(REG_PE, {6'h00, o[6], v[6]});
      cyc(8);
      `CHK(port_a_out_o, v[5:0])
      `CHK(port_a_oe_o, o[5:0])
      `CHK({general_io_line_8_oe_o, general_io_line_8_out_o}, {o[6], v[6]})
      rd(REG_PINS, d);
      `CHK(d[6:0], plv(v[6:0], o[6:0], ext_val))
    end
    wr(REG_PA_OE, 8'h00);
    wr(REG_PE, 8'h00);
    ext_val <= 7'h7f;
    cyc(8);
    rd(REG_STATUS, d);
    // both interrupt inputs, edge and level, second one masked
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 2; t++) begin
        wr(REG_ALT_CFG, 8'(1 << k));
        wr(REG_CTRL, 8'(t << k));
        wr(REG_MASK, 8'(k == 0 ? 1 : 0));
        cyc(8);
        rd(REG_STATUS, d);
        ext_val[k] <= 1'b0;
        cyc(8);
        `CHK(k ? ext_irq_second_o : ext_irq_first_o, 1'b1)
        `CHK(irq_o, 1'(t == 1 && k == 0))
        ext_val[k] <= 1'b1;
        cyc(8);
        `CHK(k ? ext_irq_second_o : ext_irq_first_o, 1'(t))
        rd(REG_STATUS, d);
        `CHK(d[k], 1'(t))
        cyc(2);
        `CHK(irq_o, 1'b0)
      end
    end
    wr(REG_ALT_CFG, 8'h00);
    wr(REG_CTRL, 8'h00);
    // slave FIFO mode: input-only enable and selects, even with all enables set
    wr(REG_PA_OE, 8'h3f);
    wr(REG_IF_CFG, {6'h00, IFC_SLAVE_FIFO});
    for (int n = 0; n < 6; n++) begin
      p = 1'($urandom);
      wr(REG_FIFO_POL, 8'(p) << FPOL_OE);
      ext_val <= 7'($urandom);
      cyc(8);
      `CHK(fifo_output_enable_o, fexp(p, ext_val[2]))
      `CHK(fifo_select_o, ext_val[5:4])
      `CHK({port_a_oe_o[5:4], port_a_oe_o[2]}, 3'h0)
    end
    wr(REG_IF_CFG, 8'h00);
    wr(REG_PA_OE, 8'h00);
    // NAND mode: core levels out on the pins, switch read back
    wr(REG_CTRL, 8'h04);
    for (int n = 0; n < 6; n++) begin
      {cle, ale, wp, l1, l2} <= 5'($urandom);
      ext_val[5] <= 1'($urandom);
      cyc(8);
      `CHK({port_a_out_o[4], port_a_out_o[1:0]}, {wp, ale, cle})
      `CHK(port_a_oe_o & 6'h33, 6'h13)
      `CHK(write_protect_switch_n_o, ext_val[5])
      `CHK({port_a_oe_o[2], port_a_out_o[2]}, {~l1, 1'b0})
      `CHK({port_a_oe_o[3], port_a_out_o[3]}, {~l2, 1'b0})
    end
    wr(REG_CTRL, 8'h00);
    ext_val <= 7'h7f;
    // dedicated wake pin at both polarities
    for (int q = 0; q < 2; q++) begin
      wr(REG_WAKE_CTL, 8'(q) << WCTL_POL);
      wake_pin_i <= ~1'(q);
      cyc(8);
      rd(REG_STATUS, d);
      wr(REG_MASK, 8'h04);
      wr(REG_CTRL, 8'h08);
      cyc(1);
      `CHK({suspended_o, osc_enable_o}, 2'b10)
      wake_pin_i <= 1'(q);
      wait_run();
      `CHK({suspended_o, osc_enable_o, irq_o}, 3'b011)
      rd(REG_STATUS, d);
      `CHK(d[ST_WAKE_PIN], 1'b1)
      wr(REG_CTRL, 8'h08);
      cyc(1);
      `CHK(suspended_o, 1'b0)
      rd(REG_STATUS, d);
      `CHK(d[ST_REFUSED], 1'b1)
      wake_pin_i <= ~1'(q);
      cyc(8);
    end
    // second wake source on port A bit 3, enabled and disabled
    for (int q = 0; q < 4; q++) begin
      p = 1'(q >> 1);
      wr(REG_WAKE_CTL, 8'h80 | 8'(q[0] << WCTL_WAKE2_EN) | 8'(p) << WCTL_POL);
      wake_pin_i <= ~p;
      ext_val[3] <= ~p;
      cyc(8);
      rd(REG_STATUS, d);
      wr(REG_CTRL, 8'h08);
      cyc(1);
      `CHK(suspended_o, 1'b1)
      ext_val[3] <= p;
      cyc(12);
      `CHK(suspended_o, ~q[0])
      wake_pin_i <= p;
      wait_run();
      wake_pin_i <= ~p;
      cyc(8);
      rd(REG_STATUS, d);
      `CHK(d[ST_WAKE_SECOND], q[0])
      wr(REG_CTRL, 8'h08);
      cyc(1);
      `CHK(suspended_o, ~q[0])
      ext_val[3] <= ~p;
      wake_pin_i <= p;
      wait_run();
      wake_pin_i <= ~p;
      cyc(8);
    end
    conclude();
  end
endmodule
